// File: dlu_pkg.sv
// Shared constants and types for the port-1 mode pin and signalling block
`default_nettype none
package dlu_pkg;

   // System clock rate
   localparam int CLK_HZ = 25_000_000;

   // Three-state mode pin observation window, in ns and in cycles
   localparam int MODE_WIN_NS  = 2560;
   localparam int MODE_WIN_CYC = (MODE_WIN_NS * (CLK_HZ / 1_000_000)) / 1000;
   // Least number of toggles in a window that counts as clocked
   localparam int MODE_MIN_TOG = 4;

   // Serial frame: one address byte then one data byte
   localparam int SP_BITS     = 8;
   localparam logic [3:0] SP_LAST_BIT = 4'h7;
   // Address bit that marks a read
   localparam int SP_RD_BIT   = 0;

   // Positions of the asynchronous inputs in the sampled vector
   localparam int IN_MCLK   = 0;
   localparam int IN_JPL    = 1;
   localparam int IN_AUXSEL = 2;
   localparam int IN_SCE    = 3;
   localparam int IN_EDGE   = 4;
   localparam int IN_TCLK   = 5;
   localparam int IN_TPOS   = 6;
   localparam int IN_TNEG   = 7;
   localparam int IN_SCLK   = 8;
   localparam int IN_SWI    = 9;
   localparam int IN_SEL_N  = 10;
   localparam int IN_RCLK   = 11;
   localparam int IN_LOS    = 12;
   localparam int IN_AUX    = 13;
   localparam int IN_BIP    = 14;
   localparam int IN_RPOS   = 15;
   localparam int IN_RNEG   = 16;
   localparam int IN_W      = 17;

   // Number of three-state mode pins, in vector order from IN_JPL
   localparam int MODE_PINS = 3;
   localparam int MP_JPL    = 0;
   localparam int MP_AUXSEL = 1;
   localparam int MP_SCE    = 2;

   // Reset values
   localparam logic RST_BIT = 1'b0;

   // Decoded state of a three-state mode pin
   typedef enum logic [1:0] {
      PS_LOW     = 2'b00,
      PS_HIGH    = 2'b01,
      PS_CLOCKED = 2'b10
   } dlu_pin_t;

   // Serial port sequence
   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_ADDR = 2'b01,
      SP_DATA = 2'b10,
      SP_DONE = 2'b11
   } dlu_sp_t;

   // One bipolar line symbol
   typedef struct packed {
      logic pos;
      logic neg;
   } dlu_sym_t;

endpackage : dlu_pkg
`default_nettype wire

// File: dlu_mode_decode.sv
// Three-state mode pin decoder: high, low or clocked by the master clock
`default_nettype none
`timescale 1ns/1ns
module dlu_mode_decode
   import dlu_pkg::*;
#(
   parameter int WIN     = MODE_WIN_CYC,
   parameter int MIN_TOG = MODE_MIN_TOG
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Synchronised pin level
   input  wire logic pinLevel,
   // Decoded state
   output dlu_pin_t  pinState
);

   localparam int CW = $clog2(WIN + 1);

   typedef struct packed {
      logic          prev;
      logic [CW-1:0] winCnt;
      logic [CW-1:0] togCnt;
      dlu_pin_t      state;
   } dlu_dec_t;

   dlu_dec_t s_r;
   dlu_dec_t s_nxt;

   // Count toggles over the window, classify at its end
   always_comb begin
      s_nxt        = s_r;
      s_nxt.prev   = pinLevel;
      s_nxt.winCnt = s_r.winCnt + CW'(1);
      if ((pinLevel != s_r.prev) && (s_r.togCnt != CW'(WIN)))
         s_nxt.togCnt = s_r.togCnt + CW'(1);
      if (s_r.winCnt == CW'(WIN - 1)) begin
         s_nxt.winCnt = '0;
         s_nxt.togCnt = '0;
         if (s_r.togCnt >= CW'(MIN_TOG))
            s_nxt.state = PS_CLOCKED;
         else
            s_nxt.state = pinLevel ? PS_HIGH : PS_LOW;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n)
         s_r <= '{prev: RST_BIT, winCnt: '0, togCnt: '0, state: PS_LOW};
      else
         s_r <= s_nxt;
   end

   assign pinState = s_r.state;

   // Enough toggles in a window gives the clocked state
   mode_clocked_a : assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.winCnt == CW'(WIN - 1) && s_r.togCnt >= CW'(MIN_TOG))
      |=> pinState == PS_CLOCKED) else $error("mode pin not seen clocked");

   // A quiet pin takes its level
   mode_level_a : assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.winCnt == CW'(WIN - 1) && s_r.togCnt < CW'(MIN_TOG))
      |=> pinState == ($past(pinLevel) ? PS_HIGH : PS_LOW))
      else $error("mode pin level wrong");

endmodule : dlu_mode_decode
`default_nettype wire

// File: dlu_port1_io.sv
// Port-1 mode pin decoding, serial port and framer-side signalling
//
// Overview of operation
// - Placement pin high: smoother in receive paths
// - Placement pin low: smoother in transmit paths
// - Placement pin clocked: smoother bypassed, disabled
// - Aux select pin chooses aux pin function
// - Serial enable clocked: host mode via serial
// - Aux select high: aux pins are violation inputs
// - Aux select low: aux pins output high-rate clock
// - Aux select clocked: QRSS function, flags report
// - Edge select high: read bit valid rising
// - Edge select low: read bit valid falling
// - Receive clock normally from recovered line clock
// - Signal absent: receive clock from master clock
// - Bipolar mode: separate positive, negative receive outputs
// - Transmit pair sampled on transmit clock fall
// - Serial write data sampled on serial rise
// - Pattern flag reports AIS reception, and QRSS reception only with aux select clocked
//
// The strobed register port was chosen for this implementation.
`default_nettype none
`timescale 1ns/1ns
module dlu_port1_io
   import dlu_pkg::*;
#(
   parameter int DW = SP_BITS
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Mode pins and master clock
   input  wire logic          mclkPin,
   input  wire logic          jitterPlacementPin,
   input  wire logic          auxFunctionSelectPin,
   input  wire logic          serialControlEnablePin,
   input  wire logic          bipolarModePin,
   // Serial port pins
   input  wire logic          sclkPin,
   input  wire logic          serialWriteIn,
   input  wire logic          port1Select_n,
   input  wire logic          edgeSelectInput,
   output logic               serialReadOut,
   // Framer transmit pins
   input  wire logic          port1TransmitClock,
   input  wire logic          port1TxPositive,
   input  wire logic          port1TxNegative,
   // Framer receive pins
   output logic               port1ReceiveClock,
   output logic               port1RxPositive,
   output logic               port1RxNegative,
   output logic               port1PatternFlag,
   // Port-1 auxiliary two-way pin
   input  wire logic          port1AuxFunctionPinIn,
   output logic               port1AuxFunctionPinOut,
   output logic               port1AuxFunctionPinOe,
   // Line receiver side
   input  wire logic          recClk,
   input  wire logic          recPos,
   input  wire logic          recNeg,
   input  wire logic          signalAbsent,
   input  wire logic          aisSeen,
   input  wire logic          qrssSeen,
   // Line transmitter side
   output dlu_sym_t           txSym,
   output logic               txStrobe,
   output logic               bpvInsert,
   output logic               qrssEnable,
   // Jitter smoother placement and host mode
   output logic               jitterSmootherRx,
   output logic               jitterSmootherTx,
   output logic               hostMode,
   // Register access from the serial port
   input  wire logic [DW-1:0] regRdData,
   output logic [DW-1:0]      regAddr,
   output logic [DW-1:0]      regWrData,
   output logic               regWrStrobe,
   output logic               regRdStrobe
);

   // Rising edge between the delayed and current synced samples
   function automatic logic risen(input logic cur, input logic old);
      return cur & ~old;
   endfunction : risen

   // Falling edge between the delayed and current synced samples
   function automatic logic fallen(input logic cur, input logic old);
      return ~cur & old;
   endfunction : fallen

   typedef struct packed {
      logic [IN_W-1:0] s1;
      logic [IN_W-1:0] s2;
      logic [IN_W-1:0] s3;
      logic            jaRx;
      logic            jaTx;
      logic            host;
      logic            auxOut;
      logic            auxOe;
      logic            bpvIns;
      logic            qrssEn;
      logic            patFlag;
      logic            hfcDiv;
      logic            rclk;
      logic            rxPos;
      logic            rxNeg;
      dlu_sym_t        txSym;
      logic            txStb;
      dlu_sp_t         sp;
      logic [3:0]      bitCnt;
      logic [DW-1:0]   shIn;
      logic [DW-1:0]   shOut;
      logic            isRead;
      logic            rdPend;
      logic            holdFirst;
      logic            serial_read_out;
      logic [DW-1:0]   addr;
      logic [DW-1:0]   wrData;
      logic            wrStb;
      logic            rdStb;
   } dlu_io_t;

   dlu_io_t         s_r;
   dlu_io_t         s_nxt;
   logic [IN_W-1:0] pinsIn;
   dlu_pin_t        modeState [MODE_PINS];
   logic            sclkRise;
   logic            sclkFall;
   logic            launch;
   logic [DW-1:0]   shInNext;

   // Gather all asynchronous inputs for the synchroniser
   always_comb begin
      pinsIn            = '0;
      pinsIn[IN_MCLK]   = mclkPin;
      pinsIn[IN_JPL]    = jitterPlacementPin;
      pinsIn[IN_AUXSEL] = auxFunctionSelectPin;
      pinsIn[IN_SCE]    = serialControlEnablePin;
      pinsIn[IN_EDGE]   = edgeSelectInput;
      pinsIn[IN_TCLK]   = port1TransmitClock;
      pinsIn[IN_TPOS]   = port1TxPositive;
      pinsIn[IN_TNEG]   = port1TxNegative;
      pinsIn[IN_SCLK]   = sclkPin;
      pinsIn[IN_SWI]    = serialWriteIn;
      pinsIn[IN_SEL_N]  = port1Select_n;
      pinsIn[IN_RCLK]   = recClk;
      pinsIn[IN_LOS]    = signalAbsent;
      pinsIn[IN_AUX]    = port1AuxFunctionPinIn;
      pinsIn[IN_BIP]    = bipolarModePin;
      pinsIn[IN_RPOS]   = recPos;
      pinsIn[IN_RNEG]   = recNeg;
   end

   // One decoder per three-state mode pin
   for (genvar g = 0; g < MODE_PINS; g++) begin : g_mode
      dlu_mode_decode u_dec (
         .clk      (clk),
         .rst_n    (rst_n),
         .pinLevel (s_r.s2[IN_JPL + g]),
         .pinState (modeState[g])
      );
   end

   // Serial clock edges and the edge that launches read bits
   assign sclkRise = risen(s_r.s2[IN_SCLK], s_r.s3[IN_SCLK]);
   assign sclkFall = fallen(s_r.s2[IN_SCLK], s_r.s3[IN_SCLK]);
   assign launch   = s_r.s2[IN_EDGE] ? sclkFall : sclkRise;
   assign shInNext = {s_r.s2[IN_SWI], s_r.shIn[DW-1:1]};

   // Next-state logic
   always_comb begin
      s_nxt       = s_r;
      s_nxt.s1    = pinsIn;
      s_nxt.s2    = s_r.s1;
      s_nxt.s3    = s_r.s2;
      s_nxt.txStb = 1'b0;
      s_nxt.wrStb = 1'b0;
      s_nxt.rdStb = 1'b0;

      // Jitter smoother placement
      unique case (modeState[MP_JPL])
         PS_HIGH: begin
            s_nxt.jaRx = 1'b1;
            s_nxt.jaTx = 1'b0;
         end
         PS_LOW: begin
            s_nxt.jaRx = 1'b0;
            s_nxt.jaTx = 1'b1;
         end
         default: begin
            s_nxt.jaRx = 1'b0;
            s_nxt.jaTx = 1'b0;
         end
      endcase

      // Host mode from the serial enable pin
      s_nxt.host = (modeState[MP_SCE] == PS_CLOCKED);

      // Auxiliary pin function
      s_nxt.hfcDiv  = ~s_r.hfcDiv;
      s_nxt.auxOut  = 1'b0;
      s_nxt.auxOe   = 1'b0;
      s_nxt.bpvIns  = 1'b0;
      s_nxt.qrssEn  = 1'b0;
      s_nxt.patFlag = aisSeen;
      unique case (modeState[MP_AUXSEL])
         PS_HIGH: begin
            s_nxt.bpvIns = s_r.s2[IN_AUX];
         end
         PS_LOW: begin
            s_nxt.auxOe  = 1'b1;
            s_nxt.auxOut = s_r.hfcDiv;
         end
         PS_CLOCKED: begin
            s_nxt.qrssEn  = s_r.s2[IN_AUX];
            s_nxt.patFlag = aisSeen | qrssSeen;
         end
         default: begin
            s_nxt.auxOe = 1'b0;
         end
      endcase

      // Receive clock source
      s_nxt.rclk = s_r.s2[IN_LOS] ? s_r.s2[IN_MCLK]
                                  : s_r.s2[IN_RCLK];

      // Bipolar receive data on recovered clock rise
      if (!s_r.s2[IN_BIP] || s_r.s2[IN_LOS]) begin
         s_nxt.rxPos = 1'b0;
         s_nxt.rxNeg = 1'b0;
      end else if (risen(s_r.s2[IN_RCLK], s_r.s3[IN_RCLK])) begin
         s_nxt.rxPos = s_r.s3[IN_RPOS];
         s_nxt.rxNeg = s_r.s3[IN_RNEG];
      end

      // Bipolar transmit pair taken on transmit clock fall
      if (s_r.s2[IN_BIP] && fallen(s_r.s2[IN_TCLK], s_r.s3[IN_TCLK])) begin
         s_nxt.txSym.pos = s_r.s3[IN_TPOS];
         s_nxt.txSym.neg = s_r.s3[IN_TNEG];
         s_nxt.txStb     = 1'b1;
      end

      // Serial port sequence
      if (!s_r.host || s_r.s2[IN_SEL_N]) begin
         s_nxt.sp     = SP_IDLE;
         s_nxt.rdPend = 1'b0;
         s_nxt.serial_read_out    = 1'b0;
      end else begin
         unique case (s_r.sp)
            SP_IDLE: begin
               if (s_r.s3[IN_SEL_N]) begin  // Select just went low
                  s_nxt.sp     = SP_ADDR;
                  s_nxt.bitCnt = 4'h0;
                  s_nxt.isRead = 1'b0;
               end
            end
            SP_ADDR: begin
               if (sclkRise) begin
                  s_nxt.shIn   = shInNext;
                  s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                  if (s_r.bitCnt == SP_LAST_BIT) begin
                     s_nxt.addr   = shInNext;
                     s_nxt.isRead = shInNext[SP_RD_BIT];
                     s_nxt.rdStb  = shInNext[SP_RD_BIT];
                     s_nxt.rdPend = shInNext[SP_RD_BIT];
                     s_nxt.bitCnt = 4'h0;
                     s_nxt.sp     = SP_DATA;
                  end
               end
            end
            SP_DATA: begin
               if (!s_r.isRead) begin
                  if (sclkRise) begin
                     s_nxt.shIn   = shInNext;
                     s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                     if (s_r.bitCnt == SP_LAST_BIT) begin
                        s_nxt.wrData = shInNext;
                        s_nxt.wrStb  = 1'b1;
                        s_nxt.sp     = SP_DONE;
                     end
                  end
               end else if (s_r.rdStb) begin
                  s_nxt.rdPend = 1'b1;  // Answer stands in the next cycle
               end else if (s_r.rdPend) begin
                  // Read data answer one cycle after the strobe
                  s_nxt.rdPend    = 1'b0;
                  s_nxt.shOut     = regRdData;
                  s_nxt.serial_read_out       = regRdData[0];
                  s_nxt.holdFirst = s_r.s2[IN_EDGE];
               end else if (launch) begin
                  if (s_r.holdFirst) begin
                     // First bit must still stand at the next rise
                     s_nxt.holdFirst = 1'b0;
                  end else begin
                     s_nxt.shOut  = {1'b0, s_r.shOut[DW-1:1]};
                     s_nxt.serial_read_out    = s_r.shOut[1];
                     s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                     if (s_r.bitCnt == SP_LAST_BIT - 4'h1)
                        s_nxt.sp = SP_DONE;
                  end
               end
            end
            SP_DONE: begin
               s_nxt.sp = SP_DONE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // Outputs straight from the state register
   assign serialReadOut          = s_r.serial_read_out;
   assign port1ReceiveClock      = s_r.rclk;
   assign port1RxPositive        = s_r.rxPos;
   assign port1RxNegative        = s_r.rxNeg;
   assign port1PatternFlag       = s_r.patFlag;
   assign port1AuxFunctionPinOut = s_r.auxOut;
   assign port1AuxFunctionPinOe  = s_r.auxOe;
   assign txSym                  = s_r.txSym;
   assign txStrobe               = s_r.txStb;
   assign bpvInsert              = s_r.bpvIns;
   assign qrssEnable             = s_r.qrssEn;
   assign jitterSmootherRx       = s_r.jaRx;
   assign jitterSmootherTx       = s_r.jaTx;
   assign hostMode               = s_r.host;
   assign regAddr                = s_r.addr;
   assign regWrData              = s_r.wrData;
   assign regWrStrobe            = s_r.wrStb;
   assign regRdStrobe            = s_r.rdStb;

   default clocking dlu_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   ja_receive_a : assert property (modeState[MP_JPL] == PS_HIGH
      |=> jitterSmootherRx && !jitterSmootherTx) else $error("smoother not in rx");

   ja_transmit_a : assert property (modeState[MP_JPL] == PS_LOW
      |=> !jitterSmootherRx && jitterSmootherTx) else $error("smoother not in tx");

   ja_bypass_a : assert property (modeState[MP_JPL] == PS_CLOCKED
      |=> !jitterSmootherRx && !jitterSmootherTx) else $error("smoother not off");

   host_mode_a : assert property (hostMode == $past(modeState[MP_SCE] == PS_CLOCKED))
      else $error("host mode wrong");

   aux_violation_a : assert property (modeState[MP_AUXSEL] == PS_HIGH
      |=> !port1AuxFunctionPinOe && bpvInsert == $past(s_r.s2[IN_AUX]))
      else $error("violation input wrong");

   aux_clock_a : assert property ((modeState[MP_AUXSEL] == PS_LOW) [*3]
      |-> port1AuxFunctionPinOe && $changed(port1AuxFunctionPinOut))
      else $error("high-rate clock missing");

   qrss_flag_a : assert property (modeState[MP_AUXSEL] == PS_CLOCKED
      |=> port1PatternFlag == $past(aisSeen | qrssSeen) && !port1AuxFunctionPinOe)
      else $error("qrss flag wrong");

   rclk_master_a : assert property (s_r.s2[IN_LOS]
      |=> port1ReceiveClock == $past(s_r.s2[IN_MCLK])) else $error("rclk not master");

   rclk_recovered_a : assert property (!s_r.s2[IN_LOS]
      |=> port1ReceiveClock == $past(s_r.s2[IN_RCLK])) else $error("rclk not line");

   tx_fall_a : assert property (txStrobe
      |-> $past(s_r.s3[IN_TCLK] && !s_r.s2[IN_TCLK] && s_r.s2[IN_BIP])
          && txSym.pos == $past(s_r.s3[IN_TPOS])) else $error("tx sample wrong");

   sdo_rise_a : assert property (s_r.sp == SP_DATA && s_r.isRead && !s_r.rdPend
      && s_r.s2[IN_EDGE] && sclkRise |=> $stable(serialReadOut))
      else $error("read bit moved at rise");

   sdo_fall_a : assert property (s_r.sp == SP_DATA && s_r.isRead && !s_r.rdPend
      && !s_r.s2[IN_EDGE] && sclkFall |=> $stable(serialReadOut))
      else $error("read bit moved at fall");

   write_capture_a : assert property (regWrStrobe
      |-> $past(sclkRise) && regWrData[DW-1] == $past(s_r.s2[IN_SWI]))
      else $error("write bit not from rise");

   rx_bipolar_a : assert property (!s_r.s2[IN_BIP]
      |=> !port1RxPositive && !port1RxNegative) else $error("rx data outside bipolar");

endmodule : dlu_port1_io
`default_nettype wire

// File: dlu_framer_model.sv
// Framer model: port-1 transmit clock and bipolar transmit pair
`timescale 1ns/1ns
`default_nettype none
module dlu_framer_model (
   // Clock and run control
   input  wire logic clk,
   input  wire logic run,
   // Framer transmit pins
   output logic      tclk,
   output logic      tpos,
   output logic      tneg
);
   logic [2:0]  ph = 3'h0;
   logic [15:0] lf = 16'hACE1;

   // Pins start low
   initial begin
      tclk = 1'h0;
      tpos = 1'h0;
      tneg = 1'h0;
   end

   // Clock of eight system cycles, only stopped after a whole period
   always @(posedge clk) begin
      if (run || ph != 3'h0) begin
         ph <= ph + 3'h1;
         tclk <= (ph < 3'h4); // Scaled line rate
         if (ph == 3'h0) begin
            lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            tpos <= lf[0]; // Changes at rise only
            tneg <= lf[1] & ~lf[0]; // Never both marks
         end
      end else begin
         tclk <= 1'h0;
         tpos <= ~tpos; // Released pair gives no stale value
         tneg <= ~tneg;
      end
   end
endmodule : dlu_framer_model
`default_nettype wire

// File: dlu_port1_io_tb.sv
// Testbench for the port-1 mode pin and signalling block
`timescale 1ns/1ns
`default_nettype none
module dlu_port1_io_tb
   import dlu_pkg::*;
;
   logic clk, rst_n = 1'h0, mclkPin = 1'h0, jitterPlacementPin = 1'h0;
   logic auxFunctionSelectPin = 1'h0, serialControlEnablePin = 1'h0, bipolarModePin = 1'h1;
   logic sclkPin = 1'h0, serialWriteIn = 1'h0, port1Select_n = 1'h1, edgeSelectInput = 1'h0;
   logic recClk = 1'h0, recPos = 1'h0, recNeg = 1'h0, signalAbsent = 1'h0, aisSeen = 1'h0;
   logic qrssSeen = 1'h1, auxDrv = 1'h1, run = 1'h0, rcOn = 1'h0, tcD = 1'h0;
   logic serialReadOut, port1ReceiveClock, port1RxPositive, port1RxNegative, port1PatternFlag;
   logic txStrobe, bpvInsert, qrssEnable, jitterSmootherRx, jitterSmootherTx, hostMode;
   logic regWrStrobe, regRdStrobe, port1AuxFunctionPinOut, port1AuxFunctionPinOe;
   logic tclk, tpos, tneg;
   logic [7:0]  regRdData = 8'h00, rdVal = 8'h00, regAddr, regWrData;
   logic [1:0]  pc = 2'h0;
   logic [2:0]  hr = 3'h0, hm = 3'h0, rc = 3'h0;
   logic [3:0]  mc = 4'h0;
   logic [15:0] sd = 16'h12D1;
   dlu_sym_t    txSym;
   wire logic   port1AuxFunctionPinIn;
   int          err_total = 0, checks = 0;
   logic [1:0]  txQ[$];
   logic [16:0] rbQ[$];

   dlu_port1_io #(.DW(8)) uut (
      .clk, .rst_n, .mclkPin, .jitterPlacementPin, .auxFunctionSelectPin,
      .serialControlEnablePin, .bipolarModePin, .sclkPin, .serialWriteIn, .port1Select_n,
      .edgeSelectInput, .serialReadOut, .port1TransmitClock(tclk), .port1TxPositive(tpos),
      .port1TxNegative(tneg), .port1ReceiveClock, .port1RxPositive, .port1RxNegative,
      .port1PatternFlag, .port1AuxFunctionPinIn, .port1AuxFunctionPinOut,
      .port1AuxFunctionPinOe, .recClk, .recPos, .recNeg, .signalAbsent, .aisSeen, .qrssSeen,
      .txSym, .txStrobe, .bpvInsert, .qrssEnable, .jitterSmootherRx, .jitterSmootherTx,
      .hostMode, .regRdData, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe
   );
   dlu_framer_model fm (.clk, .run, .tclk, .tpos, .tneg);

   // Aux wire level from both drivers
   assign port1AuxFunctionPinIn = port1AuxFunctionPinOe ? port1AuxFunctionPinOut : auxDrv;

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic results();
      if (txQ.size() != 0 || rbQ.size() != 0)
         err_total++;
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   // Master clock, recovered clock and three-state mode pins
   always @(posedge clk) begin
      mc <= (mc == 4'h5) ? 4'h0 : mc + 4'h1;
      if (mc == 4'h5)
         mclkPin <= ~mclkPin;
      rc <= rc + 3'h1;
      recClk <= rc[2];
      recPos <= rc[1];
      recNeg <= rc[0] & ~rc[1];
      jitterPlacementPin <= (pc == 2'h2) ? mclkPin : pc[0];
      auxFunctionSelectPin <= (pc == 2'h2) ? mclkPin : pc[0];
      serialControlEnablePin <= (pc == 2'h2) ? mclkPin : pc[0];
   end

   // Watcher: oldest note against each result as it appears
   always @(posedge clk) begin
      tcD <= tclk;
      if (tcD && !tclk)
         txQ.push_back({tpos, tneg});
      if (txStrobe === 1'h1)
         chk("txSym", 17'(txQ.pop_front()), 17'({txSym.pos, txSym.neg}));
      // Register file answer only in the cycle after a read strobe
      regRdData <= (regRdStrobe === 1'h1) ? rdVal : 8'h00;
      if (regWrStrobe === 1'h1 || regRdStrobe === 1'h1)
         chk("regBus", rbQ.pop_front(),
             {regRdStrobe, regAddr, regRdStrobe ? 8'h00 : regWrData});
   end

   // Receive clock against its source three cycles earlier
   always @(negedge clk) begin
      hr <= {hr[1:0], recClk};
      hm <= {hm[1:0], mclkPin};
      if (rcOn) begin
         chk("rxClock", 17'(signalAbsent ? hm[2] : hr[2]), 17'(port1ReceiveClock));
         chk("rxPos", 17'(!signalAbsent), 17'(port1RxPositive));
         chk("rxNeg", 17'h0, 17'(port1RxNegative));
      end
   end

   // Same state on all mode pins, then the decoded outputs
   task automatic mode(input logic [1:0] c);
      logic o;
      pc <= c;
      aisSeen <= (c == 2'h1);
      repeat (200) @(posedge clk);
      chk("smootherRx", 17'(c == 2'h1), 17'(jitterSmootherRx));
      chk("smootherTx", 17'(c == 2'h0), 17'(jitterSmootherTx));
      chk("hostMode", 17'(c == 2'h2), 17'(hostMode));
      chk("auxOe", 17'(c == 2'h0), 17'(port1AuxFunctionPinOe));
      chk("bpvInsert", 17'(c == 2'h1), 17'(bpvInsert));
      chk("qrssEnable", 17'(c == 2'h2), 17'(qrssEnable));
      chk("patternFlag", 17'(c != 2'h0), 17'(port1PatternFlag));
      o = port1AuxFunctionPinOut;
      @(posedge clk);
      chk("auxOut", 17'((c == 2'h0) & ~o), 17'(port1AuxFunctionPinOut));
   endtask : mode

   // One serial bit; read line sampled just before each edge
   task automatic sbit(input logic d, output logic r, output logic f);
      serialWriteIn <= d;
      repeat (8) @(posedge clk);
      r = serialReadOut;
      sclkPin <= 1'h1;
      repeat (8) @(posedge clk);
      f = serialReadOut;
      sclkPin <= 1'h0;
   endtask : sbit

   // Address then data byte, least significant bit first
   task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic e);
      logic [15:0] r;
      logic [15:0] f;
      logic [15:0] w;
      w = {d, a};
      edgeSelectInput <= e;
      rbQ.push_back({a[0], a, a[0] ? 8'h00 : d});
      port1Select_n <= 1'h0;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 16; i++)
         sbit(w[i], r[i], f[i]);
      if (a[0])
         chk("readOut", 17'(d), 17'(e ? r[15:8] : f[14:7]));
      port1Select_n <= 1'h1;
      repeat (8) @(posedge clk);
   endtask : frame

   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      for (int c = 0; c < 3; c++)
         mode(2'(c));
      for (int k = 0; k < 3; k++) begin
         sd = lfsr(sd);
         rdVal <= sd[7:0];
         frame({sd[15:9], k != 0}, sd[7:0], k[0]);
      end
      run <= 1'h1;
      repeat (120) @(posedge clk);
      run <= 1'h0;
      repeat (20) @(posedge clk);
      rcOn <= 1'h1;
      repeat (40) @(posedge clk);
      rcOn <= 1'h0;
      signalAbsent <= 1'h1;
      repeat (6) @(posedge clk);
      rcOn <= 1'h1;
      repeat (40) @(posedge clk);
      results();
   end

   // Run limit
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      results();
   end
endmodule : dlu_port1_io_tb
`default_nettype wire
